/* common/fpa_pkg.sv */
// shared constants and types for the program and data flash access block
package fpa_pkg;
   // command register codes
   localparam logic [7:0] CMD_PG_READ   = 8'h01;
   localparam logic [7:0] CMD_PG_WRITE  = 8'h02;
   localparam logic [7:0] CMD_VERIFY    = 8'h04;
   localparam logic [7:0] CMD_ER_PAGE   = 8'h05;
   localparam logic [7:0] CMD_ER_ALL    = 8'h06;
   localparam logic [7:0] CMD_BY_READ   = 8'h81;
   localparam logic [7:0] CMD_BY_WRITE  = 8'h82;
   localparam logic [7:0] CMD_ENTER_UPD = 8'hF0;
   localparam logic [7:0] CMD_LEAVE_UPD = 8'h0F;
   // special function register selects
   localparam int         SEL_W         = 3;
   localparam logic [2:0] SEL_CMD       = 3'h0;
   localparam logic [2:0] SEL_DATA1     = 3'h1;
   localparam logic [2:0] SEL_DATA2     = 3'h2;
   localparam logic [2:0] SEL_DATA3     = 3'h3;
   localparam logic [2:0] SEL_DATA4     = 3'h4;
   localparam logic [2:0] SEL_ADDR_HI   = 3'h5;
   localparam logic [2:0] SEL_ADDR_LO   = 3'h6;
   // operations toward the flash macro
   localparam logic [1:0] NV_READ       = 2'h0;
   localparam logic [1:0] NV_WRITE      = 2'h1;
   localparam logic [1:0] NV_ERASE      = 2'h2;
   localparam logic [1:0] NV_ERASE_ALL  = 2'h3;
   // map figures and other fixed values
   localparam logic [15:0] ARRAY_TOP    = 16'hF800;
   localparam logic [7:0]  UPD_TOP_HI   = 8'hE0;
   localparam logic [7:0]  DL_TOP_HI    = 8'hF8;
   localparam logic [15:0] BOOT_VEC     = 16'hE000;
   localparam logic [15:0] RST_VEC      = 16'h0000;
   localparam logic [15:0] PROG_PG_MASK = 16'hFFC0;
   localparam logic [15:0] DATA_TOP     = 16'h1000;
   localparam logic [7:0]  ERASED       = 8'hFF;
   localparam logic [7:0]  VERIFY_OK    = 8'h00;
   localparam logic [7:0]  VERIFY_FAIL  = 8'h01;
   localparam logic [7:0]  LAST_BYTE    = 8'hFF;
   localparam logic [1:0]  STRAP_TAKE   = 2'h2;
   localparam logic [35:0] PIN_RST      = 36'h8_0000_0000;
   localparam logic [7:0]  CMD_RST      = 8'h00;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_CHK  = 5'b00010,
      S_XRD  = 5'b00100,
      S_WAIT = 5'b01000,
      S_NONE = 5'b10000
   } fpa_state_t;
endpackage

/* verilog/fpa_flash_access.sv */
// flash access controller: program array map, update mode and data array commands
`timescale 1ns/100ps
`default_nettype none
module fpa_flash_access (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_resetn,
   input  wire logic                    i_code_fetch_strobe_pin_n,
   input  wire logic                    i_boot_load_opt,
   input  wire logic                    i_par_prog_mode,
   input  wire logic                    i_addr_latch_strobe,
   input  wire logic [7:0]              i_programming_config_port,
   input  wire logic [7:0]              i_port_two_bus,
   input  wire logic [7:0]              i_port_one_bus,
   input  wire logic [7:0]              i_port_zero_bus,
   input  wire logic                    i_sfr_we,
   input  wire logic [fpa_pkg::SEL_W-1:0] i_sfr_sel,
   input  wire logic [7:0]              i_sfr_wdata,
   input  wire logic [15:0]             i_fetch_addr,
   input  wire logic                    i_nv_done,
   input  wire logic [31:0]             i_nv_rdata,
   input  wire logic [7:0]              i_on_chip_extended_ram_rdata,
   output logic      [7:0]              o_sfr_rdata,
   output logic                         o_core_stall,
   output logic                         o_fetch_hit,
   output logic      [15:0]             o_reset_vector,
   output logic                         o_serial_dl_mode,
   output logic                         o_user_update_mode,
   output logic                         o_nv_req,
   output logic      [1:0]              o_nv_op,
   output logic                         o_nv_array,
   output logic      [15:0]             o_nv_addr,
   output logic      [31:0]             o_nv_wdata,
   output logic      [3:0]              o_nv_be,
   output logic      [7:0]              o_on_chip_extended_ram_addr
);
   import fpa_pkg::*;

   logic [35:0] pin_s1_r, pin_s2_r;
   logic        ale_d_r;
   logic        code_fetch_strobe_pin_n_s, boot_s, par_s, ale_s;
   logic [7:0]  p3_s, p2_s, p1_s, p0_s;
   fpa_state_t  st_r, st_nxt;
   logic [7:0]  cmd_r, cmd_nxt, stat_r, stat_nxt, adh_r, adh_nxt, adl_r, adl_nxt;
   logic [7:0]  cnt_r, cnt_nxt, xb_r, xb_nxt, rd_nxt;
   logic [31:0] dat_r, dat_nxt, wd_nxt;
   logic [15:0] addr_nxt, vec_nxt;
   logic [1:0]  op_nxt, strap_r, strap_nxt;
   logic [3:0]  be_nxt;
   logic        upd_nxt, req_nxt, arr_nxt, dl_nxt, hit_nxt, stall_nxt;
   logic        par_go, core_go, copying;
   logic [7:0]  lim;

   // two-flop synchroniser on every pin; only the second stage is read
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_s1_r <= PIN_RST;
         pin_s2_r <= PIN_RST;
         ale_d_r  <= 1'b0;
      end else begin
         pin_s1_r <= {i_code_fetch_strobe_pin_n, i_boot_load_opt, i_par_prog_mode,
                      i_addr_latch_strobe, i_programming_config_port, i_port_two_bus,
                      i_port_one_bus, i_port_zero_bus};
         pin_s2_r <= pin_s1_r;
         ale_d_r  <= pin_s2_r[32];
      end
   end
   assign {code_fetch_strobe_pin_n_s, boot_s, par_s, ale_s, p3_s, p2_s, p1_s, p0_s} = pin_s2_r;

   // launch conditions; both only while idle
   assign par_go  = par_s && ale_s && !ale_d_r && (st_r == S_IDLE);
   assign core_go = !par_go && i_sfr_we && (i_sfr_sel == SEL_CMD) && (st_r == S_IDLE);
   assign copying = (cmd_r == CMD_PG_WRITE) && o_nv_array;
   // serial download owns the whole array, user code stops below the boot area
   assign lim     = o_serial_dl_mode ? DL_TOP_HI : UPD_TOP_HI;

   // next-state logic for the whole block
   always_comb begin
      logic [7:0]  c;
      logic [15:0] a;
      logic        prog, ok;
      c = CMD_RST;
      a = 16'h0000;
      prog = 1'b0;
      ok = 1'b0;
      st_nxt = st_r;    cmd_nxt = cmd_r;  stat_nxt = stat_r; dat_nxt = dat_r;
      adh_nxt = adh_r;  adl_nxt = adl_r;  upd_nxt = o_user_update_mode;
      cnt_nxt = cnt_r;  xb_nxt = xb_r;    req_nxt = o_nv_req; op_nxt = o_nv_op;
      arr_nxt = o_nv_array; addr_nxt = o_nv_addr; wd_nxt = o_nv_wdata; be_nxt = o_nv_be;
      // plain register writes from the core
      if (i_sfr_we && !core_go) begin
         unique case (i_sfr_sel)
            SEL_DATA1:   dat_nxt[7:0]   = i_sfr_wdata;
            SEL_DATA2:   dat_nxt[15:8]  = i_sfr_wdata;
            SEL_DATA3:   dat_nxt[23:16] = i_sfr_wdata;
            SEL_DATA4:   dat_nxt[31:24] = i_sfr_wdata;
            SEL_ADDR_HI: adh_nxt = i_sfr_wdata;
            SEL_ADDR_LO: adl_nxt = i_sfr_wdata;
            default: ;
         endcase
      end
      unique case (st_r)
         S_IDLE: begin
            if (par_go) begin
               c = p3_s;
               a = {p2_s, p1_s};
               prog = 1'b1;
               ok = 1'b1;
               xb_nxt = p0_s;
            end else if (core_go) begin
               c = i_sfr_wdata;
               a = {adh_r, adl_r};
               prog = o_user_update_mode;
               ok = adh_r < lim;
               xb_nxt = dat_r[7:0];
            end
            if (par_go || core_go) begin
               cmd_nxt = c;
               stat_nxt = c;
               arr_nxt = prog;
               unique case (c)
                  CMD_PG_READ, CMD_VERIFY: if (!prog) begin
                     req_nxt = 1'b1; op_nxt = NV_READ;
                     addr_nxt = {4'h0, a[9:0], 2'b00}; st_nxt = S_WAIT;
                  end
                  CMD_BY_READ: if (!prog) begin
                     req_nxt = 1'b1; op_nxt = NV_READ;
                     addr_nxt = {4'h0, a[11:0]}; st_nxt = S_WAIT;
                  end
                  CMD_PG_WRITE: if (!prog) begin
                     req_nxt = 1'b1; op_nxt = NV_READ;
                     addr_nxt = {4'h0, a[9:0], 2'b00}; st_nxt = S_CHK;
                  end else if (ok) begin
                     cnt_nxt = 8'h00; st_nxt = S_XRD;
                  end
                  CMD_BY_WRITE: if (!prog || ok) begin
                     req_nxt = 1'b1; op_nxt = NV_READ;
                     addr_nxt = prog ? a : {4'h0, a[11:0]}; st_nxt = S_CHK;
                  end
                  CMD_ER_PAGE: if (!prog || ok) begin
                     req_nxt = 1'b1; op_nxt = NV_ERASE; st_nxt = S_WAIT;
                     addr_nxt = prog ? (a & PROG_PG_MASK) : {4'h0, a[9:0], 2'b00};
                  end
                  CMD_ER_ALL: begin
                     req_nxt = 1'b1; op_nxt = NV_ERASE_ALL; st_nxt = S_WAIT;
                     addr_nxt = 16'h0000;
                  end
                  // programmer port cannot switch update mode, only the core can
                  CMD_ENTER_UPD: if (core_go) upd_nxt = 1'b1;
                  CMD_LEAVE_UPD: if (core_go) upd_nxt = 1'b0;
                  default: ;
               endcase
            end
         end
         S_XRD: begin
            // ram read is asynchronous; address has been stable a full cycle
            xb_nxt = i_on_chip_extended_ram_rdata;
            req_nxt = 1'b1; op_nxt = NV_READ;
            addr_nxt = {adh_r, cnt_r}; st_nxt = S_CHK;
         end
         S_CHK: if (i_nv_done) begin
            req_nxt = 1'b0;
            if ((cmd_r == CMD_PG_WRITE) && !o_nv_array) begin
               for (int i = 0; i < 4; i++) begin
                  be_nxt[i] = i_nv_rdata[8*i +: 8] == ERASED;
               end
               wd_nxt = dat_r;
            end else begin
               be_nxt = {3'b000, i_nv_rdata[7:0] == ERASED};
               wd_nxt = {24'h000000, xb_r};
            end
            if (be_nxt != 4'h0) begin
               req_nxt = 1'b1; op_nxt = NV_WRITE; st_nxt = S_WAIT;
            end else if (copying && cnt_r != LAST_BYTE) begin
               cnt_nxt = cnt_r + 8'h01; st_nxt = S_XRD;
            end else begin
               st_nxt = S_IDLE;
            end
         end
         S_WAIT: if (i_nv_done) begin
            req_nxt = 1'b0;
            st_nxt = S_IDLE;
            if (o_nv_op == NV_READ) begin
               if (cmd_r == CMD_PG_READ) dat_nxt = i_nv_rdata;
               if (cmd_r == CMD_BY_READ) dat_nxt[7:0] = i_nv_rdata[7:0];
               if (cmd_r == CMD_VERIFY) stat_nxt = (i_nv_rdata == dat_r) ? VERIFY_OK : VERIFY_FAIL;
            end else if (copying && cnt_r != LAST_BYTE) begin
               cnt_nxt = cnt_r + 8'h01; st_nxt = S_XRD;
            end
         end
         default: st_nxt = S_IDLE;
      endcase
      // straps are taken once the synchronisers have filled
      strap_nxt = (strap_r == 2'h3) ? strap_r : strap_r + 2'h1;
      dl_nxt  = o_serial_dl_mode;
      vec_nxt = o_reset_vector;
      if (strap_r == STRAP_TAKE) begin
         dl_nxt  = !code_fetch_strobe_pin_n_s;
         vec_nxt = boot_s ? BOOT_VEC : RST_VEC;
      end
      hit_nxt   = i_fetch_addr < ARRAY_TOP;
      stall_nxt = st_nxt != S_IDLE;
      unique case (i_sfr_sel)
         SEL_CMD:     rd_nxt = stat_nxt;
         SEL_DATA1:   rd_nxt = dat_nxt[7:0];
         SEL_DATA2:   rd_nxt = dat_nxt[15:8];
         SEL_DATA3:   rd_nxt = dat_nxt[23:16];
         SEL_DATA4:   rd_nxt = dat_nxt[31:24];
         SEL_ADDR_HI: rd_nxt = adh_nxt;
         SEL_ADDR_LO: rd_nxt = adl_nxt;
         default:     rd_nxt = 8'h00;
      endcase
   end

   // registers only; update mode clears on every reset
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= S_IDLE;        cmd_r <= CMD_RST;       stat_r <= CMD_RST;
         dat_r <= 32'h00000000; adh_r <= 8'h00;         adl_r <= 8'h00;
         cnt_r <= 8'h00;        xb_r <= 8'h00;          strap_r <= 2'h0;
         o_user_update_mode <= 1'b0;
         o_nv_req <= 1'b0;      o_nv_op <= NV_READ;     o_nv_array <= 1'b0;
         o_nv_addr <= 16'h0000; o_nv_wdata <= 32'h00000000; o_nv_be <= 4'h0;
         o_sfr_rdata <= 8'h00;  o_core_stall <= 1'b0;   o_fetch_hit <= 1'b0;
         o_reset_vector <= RST_VEC; o_serial_dl_mode <= 1'b0; o_on_chip_extended_ram_addr <= 8'h00;
      end else begin
         st_r <= st_nxt;        cmd_r <= cmd_nxt;       stat_r <= stat_nxt;
         dat_r <= dat_nxt;      adh_r <= adh_nxt;       adl_r <= adl_nxt;
         cnt_r <= cnt_nxt;      xb_r <= xb_nxt;         strap_r <= strap_nxt;
         o_user_update_mode <= upd_nxt;
         o_nv_req <= req_nxt;   o_nv_op <= op_nxt;      o_nv_array <= arr_nxt;
         o_nv_addr <= addr_nxt; o_nv_wdata <= wd_nxt;   o_nv_be <= be_nxt;
         o_sfr_rdata <= rd_nxt; o_core_stall <= stall_nxt; o_fetch_hit <= hit_nxt;
         o_reset_vector <= vec_nxt; o_serial_dl_mode <= dl_nxt; o_on_chip_extended_ram_addr <= cnt_nxt;
      end
   end

   // checks on the behaviour above
   a_stall_while_busy: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (core_go && i_sfr_wdata == CMD_ER_ALL) |=> o_core_stall && o_nv_req)
      else $error("core not stalled during operation");
   a_fetch_map_top: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_fetch_addr >= ARRAY_TOP) |=> !o_fetch_hit) else $error("fetch above array hit");
   a_boot_vector: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (strap_r == STRAP_TAKE && boot_s) |=> (o_reset_vector == BOOT_VEC))
      else $error("boot vector not applied");
   a_dl_mode_held: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (strap_r == 2'h3) |=> $stable(o_serial_dl_mode)) else $error("download mode changed");
   a_upd_entry_cause: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      $rose(o_user_update_mode) |-> $past(core_go && i_sfr_wdata == CMD_ENTER_UPD))
      else $error("update mode entered without command");
   a_prog_read_only: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (core_go && !o_user_update_mode) |=> !(o_nv_req && o_nv_array))
      else $error("program array touched outside update mode");
   a_protect_top: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (core_go && o_user_update_mode && adh_r >= lim && i_sfr_wdata != CMD_ER_ALL)
      |=> (st_r == S_IDLE) && !o_core_stall) else $error("protected region command ran");
   a_erased_only: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (st_r == S_CHK && i_nv_done && cmd_r == CMD_BY_WRITE && i_nv_rdata[7:0] != ERASED)
      |=> !o_nv_req && (st_r == S_IDLE)) else $error("write to unerased byte");
   a_prog_page_erase: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (o_nv_req && o_nv_op == NV_ERASE && o_nv_array) |-> (o_nv_addr[5:0] == 6'h00))
      else $error("program erase not page aligned");
   a_data_range: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (o_nv_req && !o_nv_array) |-> (o_nv_addr < DATA_TOP)) else $error("data address out of range");
endmodule
`default_nettype wire

/* testbench/fpa_nv_model.sv */
// behavioural flash macro and extended ram standing behind the access block
`timescale 1ns/100ps
`default_nettype none
module fpa_nv_model (
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_nv_req,
   input  wire logic [1:0]  i_nv_op,
   input  wire logic        i_nv_array,
   input  wire logic [15:0] i_nv_addr,
   input  wire logic [31:0] i_nv_wdata,
   input  wire logic [3:0]  i_nv_be,
   input  wire logic [7:0]  i_on_chip_extended_ram_addr,
   output logic             o_nv_done,
   output logic      [31:0] o_nv_rdata,
   output logic      [7:0]  o_on_chip_extended_ram_rdata
);
   import fpa_pkg::*;
   logic [7:0] dm [4096];
   logic [7:0] pm [65536];
   int         cnt;
   int         lat;
   bit         gap;
   // both arrays leave the factory erased
   initial begin
      foreach (dm[i]) dm[i] = ERASED;
      foreach (pm[i]) pm[i] = ERASED;
      o_nv_rdata = '0;
      lat = 1;
   end
   // ram answers at once; a fixed pattern lets the bench predict copies
   assign o_on_chip_extended_ram_rdata = i_on_chip_extended_ram_addr ^ 8'h3C;
   function automatic logic [7:0] rd(input logic [15:0] a);
      return i_nv_array ? pm[a] : dm[a[11:0]];
   endfunction
   // programming only clears bits, so only an erased byte takes new data
   function automatic void pr(input logic [15:0] a, input logic [7:0] v);
      if (i_nv_array) pm[a] = pm[a] & v;
      else dm[a[11:0]] = dm[a[11:0]] & v;
   endfunction
   function automatic void er(input logic [15:0] a, input int n);
      for (int i = 0; i < n; i++) begin
         if (i_nv_array) pm[int'(a) + i] = ERASED;
         else dm[int'(a[11:0]) + i] = ERASED;
      end
   endfunction
   // random latency; the cycle after done is skipped since req still stands
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_nv_done <= 1'b0;
         cnt = 0;
         gap = 1'b0;
      end else begin
         o_nv_done <= 1'b0;
         o_nv_rdata <= ~o_nv_rdata; // stale data never looks valid
         if (gap) gap = 1'b0;
         else if (i_nv_req && cnt < lat) cnt++;
         else if (i_nv_req) begin
            case (i_nv_op)
               NV_READ: o_nv_rdata <= {rd(i_nv_addr + 16'd3), rd(i_nv_addr + 16'd2),
                                       rd(i_nv_addr + 16'd1), rd(i_nv_addr)};
               NV_WRITE: for (int i = 0; i < 4; i++) begin
                  if (i_nv_be[i]) pr(i_nv_addr + 16'(i), i_nv_wdata[8*i +: 8]);
               end
               NV_ERASE: begin
                  if (i_nv_array) er(i_nv_addr & PROG_PG_MASK, 64);
                  else er(i_nv_addr & 16'hFFFC, 4);
               end
               default: er(16'h0000, i_nv_array ? 57344 : 4096);
            endcase
            o_nv_done <= 1'b1;
            cnt = 0;
            gap = 1'b1;
            lat = 1 + $urandom_range(4);
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the flash access block with a behavioural macro
`timescale 1ns/100ps
`default_nettype none
module tb;
   import fpa_pkg::*;
   logic             i_ref_clk, i_resetn, i_code_fetch_strobe_pin_n, i_boot_load_opt;
   logic             i_par_prog_mode, i_addr_latch_strobe, i_sfr_we, i_nv_done, rd_req, rd_seen;
   logic [7:0]       i_programming_config_port, i_port_two_bus, i_port_one_bus, i_port_zero_bus;
   logic [SEL_W-1:0] i_sfr_sel;
   logic [7:0]       i_sfr_wdata, i_on_chip_extended_ram_rdata, o_sfr_rdata, o_on_chip_extended_ram_addr;
   logic [15:0]      i_fetch_addr, o_reset_vector, o_nv_addr;
   logic [31:0]      i_nv_rdata, o_nv_wdata;
   logic             o_core_stall, o_fetch_hit, o_serial_dl_mode, o_user_update_mode;
   logic             o_nv_req, o_nv_array;
   logic [1:0]       o_nv_op;
   logic [3:0]       o_nv_be;
   logic [7:0]       exp_q[$];
   logic [7:0]       d[4];
   logic [15:0]      fa[4] = '{16'h0000, 16'hF7FF, 16'hF800, 16'hFFFF};
   int               err_count, check_count, n;
   fpa_flash_access i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_code_fetch_strobe_pin_n(i_code_fetch_strobe_pin_n), .i_boot_load_opt(i_boot_load_opt),
      .i_par_prog_mode(i_par_prog_mode), .i_addr_latch_strobe(i_addr_latch_strobe),
      .i_programming_config_port(i_programming_config_port), .i_port_two_bus(i_port_two_bus),
      .i_port_one_bus(i_port_one_bus), .i_port_zero_bus(i_port_zero_bus), .i_sfr_we(i_sfr_we),
      .i_sfr_sel(i_sfr_sel), .i_sfr_wdata(i_sfr_wdata), .i_fetch_addr(i_fetch_addr),
      .i_nv_done(i_nv_done), .i_nv_rdata(i_nv_rdata), .i_on_chip_extended_ram_rdata(i_on_chip_extended_ram_rdata),
      .o_sfr_rdata(o_sfr_rdata), .o_core_stall(o_core_stall), .o_fetch_hit(o_fetch_hit),
      .o_reset_vector(o_reset_vector), .o_serial_dl_mode(o_serial_dl_mode),
      .o_user_update_mode(o_user_update_mode), .o_nv_req(o_nv_req), .o_nv_op(o_nv_op),
      .o_nv_array(o_nv_array), .o_nv_addr(o_nv_addr), .o_nv_wdata(o_nv_wdata),
      .o_nv_be(o_nv_be), .o_on_chip_extended_ram_addr(o_on_chip_extended_ram_addr));
   fpa_nv_model i_nv (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_nv_req(o_nv_req),
      .i_nv_op(o_nv_op), .i_nv_array(o_nv_array), .i_nv_addr(o_nv_addr),
      .i_nv_wdata(o_nv_wdata), .i_nv_be(o_nv_be), .i_on_chip_extended_ram_addr(o_on_chip_extended_ram_addr),
      .o_nv_done(i_nv_done), .o_nv_rdata(i_nv_rdata), .o_on_chip_extended_ram_rdata(i_on_chip_extended_ram_rdata));
   // 200 MHz clock
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chkf(input logic got, input logic exp, input string what);
      chkv({15'h0, got}, {15'h0, exp}, what);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] v);
      @(negedge i_ref_clk);
      i_sfr_we = 1'b1;
      i_sfr_sel = s;
      i_sfr_wdata = v;
      @(negedge i_ref_clk);
      i_sfr_we = 1'b0;
   endtask
   // the read result is noted now and compared by the watcher a cycle later
   task automatic rd(input logic [2:0] s, input logic [7:0] e);
      @(negedge i_ref_clk);
      i_sfr_sel = s;
      exp_q.push_back(e);
      rd_req = 1'b1;
      @(negedge i_ref_clk);
      rd_req = 1'b0;
   endtask
   always @(posedge i_ref_clk) rd_seen <= rd_req;
   always @(negedge i_ref_clk) if (rd_seen === 1'b1) chkv(o_sfr_rdata, exp_q.pop_front(), "read");
   // bounded wait until neither the core nor the macro is busy
   task automatic idle();
      n = 0;
      while ((o_core_stall !== 1'b0 || o_nv_req !== 1'b0) && n < 20000) begin
         @(negedge i_ref_clk);
         n++;
      end
      chkf(n < 20000, 1'b1, "hang");
   endtask
   // st: 1 must stall, 0 refused, 2 no opinion
   task automatic cmd(input logic [7:0] c, input int st);
      wr(SEL_CMD, c);
      if (st < 2) chkf(o_core_stall, st[0], "stall");
      idle();
   endtask
   task automatic pg(input logic [7:0] hi, input logic [7:0] lo);
      wr(SEL_ADDR_HI, hi);
      wr(SEL_ADDR_LO, lo);
   endtask
   task automatic rst(input logic pin_n, input logic boot);
      @(negedge i_ref_clk);
      i_resetn = 1'b0;
      i_code_fetch_strobe_pin_n = pin_n;
      i_boot_load_opt = boot;
      repeat (5) @(negedge i_ref_clk);
      i_resetn = 1'b1;
      repeat (6) @(negedge i_ref_clk);
      chkv(o_reset_vector, boot ? BOOT_VEC : RST_VEC, "vector");
      chkf(o_serial_dl_mode, ~pin_n, "download strap");
      chkf(o_user_update_mode, 1'b0, "update after reset");
   endtask
   // hang guard, well beyond the expected run
   initial begin
      #400000;
      err_count++;
      end_of_test();
   end
   initial begin
      {i_resetn, i_par_prog_mode, i_addr_latch_strobe, i_sfr_we, rd_req} = '0;
      {i_code_fetch_strobe_pin_n, i_boot_load_opt, i_sfr_sel, i_sfr_wdata} = '0;
      {i_programming_config_port, i_port_two_bus, i_port_one_bus, i_port_zero_bus} = '0;
      i_fetch_addr = '0;
      void'($urandom(3));
      rst(1'b1, 1'b0);
      foreach (fa[i]) begin
         @(negedge i_ref_clk);
         i_fetch_addr = fa[i];
         @(negedge i_ref_clk);
         chkf(o_fetch_hit, fa[i] < ARRAY_TOP, "fetch map");
      end
      // data page write, read back, verify pass then fail
      pg(8'h00, 8'h03);
      foreach (d[i]) d[i] = 8'($urandom) & 8'hFE;
      foreach (d[i]) wr(3'(SEL_DATA1 + i), d[i]);
      cmd(CMD_PG_WRITE, 1);
      foreach (d[i]) chkv(i_nv.dm[12+i], d[i], "page stored");
      foreach (d[i]) wr(3'(SEL_DATA1 + i), 8'h00);
      cmd(CMD_PG_READ, 1);
      foreach (d[i]) rd(3'(SEL_DATA1 + i), d[i]);
      cmd(CMD_VERIFY, 1);
      rd(SEL_CMD, VERIFY_OK);
      wr(SEL_DATA2, ~d[1]);
      cmd(CMD_VERIFY, 1);
      rd(SEL_CMD, VERIFY_FAIL);
      cmd(CMD_PG_WRITE, 1);
      chkv(i_nv.dm[13], d[1], "overwrite unerased");
      // byte access in the next page survives the page erase
      pg(8'h00, 8'h10);
      wr(SEL_DATA1, 8'h5A);
      cmd(CMD_BY_WRITE, 1);
      wr(SEL_DATA1, 8'h00);
      cmd(CMD_BY_READ, 1);
      rd(SEL_DATA1, 8'h5A);
      pg(8'h00, 8'h03);
      cmd(CMD_ER_PAGE, 1);
      foreach (d[i]) chkv(i_nv.dm[12+i], ERASED, "page erase");
      chkv(i_nv.dm[16], 8'h5A, "neighbour page");
      cmd(CMD_ER_ALL, 1);
      chkv(i_nv.dm[16], ERASED, "erase all");
      rd(SEL_CMD, CMD_ER_ALL);
      chkv(i_nv.pm[12], ERASED, "program untouched");
      // update mode: lower region writable, top refused
      cmd(CMD_ENTER_UPD, 2);
      chkf(o_user_update_mode, 1'b1, "enter update");
      i_nv.pm[16'h1040] = 8'h00;
      i_nv.pm[16'hE010] = 8'h00;
      pg(8'h10, 8'h23);
      wr(SEL_DATA1, 8'hA5);
      cmd(CMD_BY_WRITE, 1);
      chkv(i_nv.pm[16'h1023], 8'hA5, "update byte");
      cmd(CMD_ER_PAGE, 1);
      chkv(i_nv.pm[16'h1023], ERASED, "prog page erase");
      chkv(i_nv.pm[16'h1040], 8'h00, "64 byte page");
      pg(8'hE0, 8'h10);
      cmd(CMD_BY_WRITE, 0);
      cmd(CMD_ER_PAGE, 0);
      cmd(CMD_PG_WRITE, 0);
      chkv(i_nv.pm[16'hE010], 8'h00, "top kept");
      cmd(CMD_PG_READ, 0);
      pg(8'h20, 8'h00);
      cmd(CMD_PG_WRITE, 1);
      for (int i = 0; i < 256; i++) chkv(i_nv.pm[16'h2000+i], 8'(i) ^ 8'h3C, "ram copy");
      cmd(CMD_LEAVE_UPD, 2);
      chkf(o_user_update_mode, 1'b0, "leave update");
      // parallel programmer writes into the top region
      @(negedge i_ref_clk);
      i_par_prog_mode = 1'b1;
      i_programming_config_port = CMD_BY_WRITE;
      {i_port_two_bus, i_port_one_bus, i_port_zero_bus} = 24'hF0103C;
      repeat (4) @(negedge i_ref_clk);
      i_addr_latch_strobe = 1'b1;
      n = 0;
      while (i_nv.pm[16'hF010] !== 8'h3C && n < 500) begin
         @(negedge i_ref_clk);
         n++;
      end
      chkv(i_nv.pm[16'hF010], 8'h3C, "parallel write");
      idle();
      {i_addr_latch_strobe, i_par_prog_mode} = 2'b00;
      // serial download reset lifts the top limit
      rst(1'b0, 1'b1);
      cmd(CMD_ENTER_UPD, 2);
      pg(8'hF0, 8'h20);
      wr(SEL_DATA1, 8'h66);
      cmd(CMD_BY_WRITE, 1);
      chkv(i_nv.pm[16'hF020], 8'h66, "download top");
      pg(8'hF8, 8'h00);
      cmd(CMD_BY_WRITE, 0);
      // update-mode erase all clears the lower region only
      cmd(CMD_ER_ALL, 1);
      chkv(i_nv.pm[16'h2000], ERASED, "update erase all");
      chkv(i_nv.pm[16'hE010], 8'h00, "boot area kept");
      end_of_test();
   end
endmodule
`default_nettype wire
